/* File: dwpr_ctrl.sv */
// Notes on behaviour
// [R1] Early write: write strobe low before column
// [R2] Hold both strobes the write lead after
// [R3] Late write: write strobe after column strobe
// [R4] Late write delay bounded by row active
// [R5] Output gate high before driving late data
// [R6] Early write leaves device output floating
// [R7] Shared bus: use early writes only
// [R8] Read-modify-write: read, then write strobe
// [R9] Page: row held, column strobe cycled
// [R10] Page starts row then column, shorter cycles
// [R11] Page may mix read, write, modify
// [R12] Refresh all 256 rows every 4 ms
// [R13] Ordinary access refreshes its row
// [R14] Row-only refresh keeps column strobe high
// [R15] Column before row uses internal counter
// [R16] Device counter advances per such refresh
// [R17] Hidden refresh: column low, row cycled
// [R18] Counter test: internal row, external column
// [R19] Eight column-first refreshes before counter test
// [R20] Counter test procedure left to requester
// [R21] Power-up pause, eight wake cycles, idle rewake
// [R22] Read data valid only while column, gate low
// [R23] Row then column on eight address pins
// [R24] Four data bits per location
`timescale 1ns/1ps
`default_nettype none
module dwpr_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [2:0] req_cmd,
  input wire logic [7:0] req_row,
  input wire logic [7:0] req_col,
  input wire logic [3:0] req_wdata,
  input wire logic req_page_next,
  output logic req_ready,
  output logic rsp_valid,
  output logic [3:0] rsp_rdata,
  output logic init_done,
  output logic row_strobe_n,
  output logic column_strobe_n,
  output logic write_strobe_n,
  output logic output_gate_n,
  output logic [7:0] mem_addr,
  output logic [3:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [3:0] mem_dq_in
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0] {
    ST_PAUSE = 4'h0,
    ST_WAKE = 4'h1,
    ST_IDLE = 4'h2,
    ST_ROW = 4'h3,
    ST_COL = 4'h4,
    ST_LATE = 4'h5,
    ST_LEAD = 4'h6,
    ST_PAGE = 4'h7,
    ST_PRE = 4'h8,
    ST_CBR_SETUP = 4'h9,
    ST_CBR_ROW = 4'ha,
    ST_HID_PRE = 4'hb
  } dwpr_st_e;

  typedef struct packed {
    dwpr_st_e st;
    logic [2:0] cmd;
    logic [7:0] col;
    logic [3:0] wdata;
    logic [3:0] wake_cnt;
    logic [3:0] cbr_cnt;
    logic [7:0] ref_row;
    logic ref_due;
    logic [19:0] ref_tmr;
    logic [19:0] idle_tmr;
    logic need_wake;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic oe_n;
    logic [7:0] addr;
    logic [3:0] dq;
    logic dq_oe;
    logic ready;
    logic rvalid;
    logic [3:0] rdata;
    logic init;
  } dwpr_ctl_s;

  dwpr_ctl_s s_r;
  dwpr_ctl_s s_nxt;
  logic tmr_load;
  logic [dwpr_pkg::TIMER_W-1:0] tmr_val;
  logic tmr_done;
  logic [3:0] dq_s1_r;
  logic [3:0] dq_s2_r;
  logic [3:0] dq_s3_r;
  logic boot_r;

  // Phase timer shared by every strobe interval
  dwpr_timer u_tmr (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // Data pins come from another domain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dq_s1_r <= 4'h0;
      dq_s2_r <= 4'h0;
      dq_s3_r <= 4'h0;
    end else begin
      dq_s1_r <= mem_dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
    end
  end

  function automatic logic is_write(input logic [2:0] c);
    return c == 3'(dwpr_pkg::DWPR_CMD_EARLY_WRITE) || c == 3'(dwpr_pkg::DWPR_CMD_LATE_WRITE);
  endfunction : is_write

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.ready = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    // Refresh interval and idle watchdog
    if (s_r.ref_tmr == 20'h00000) begin
      s_nxt.ref_due = 1'b1; // R12
      s_nxt.ref_tmr = 20'(dwpr_pkg::ROW_INTERVAL_CYC - 1);
    end else begin
      s_nxt.ref_tmr = s_r.ref_tmr - 20'h00001;
    end
    if (s_r.ras_n && s_r.idle_tmr != 20'h00000) begin
      s_nxt.idle_tmr = s_r.idle_tmr - 20'h00001;
    end else if (!s_r.ras_n) begin
      s_nxt.idle_tmr = 20'(dwpr_pkg::IDLE_LIMIT_CYC - 1);
    end
    if (s_r.idle_tmr == 20'h00001 && s_r.ras_n) begin
      s_nxt.need_wake = 1'b1; // R21
    end
    unique case (s_r.st)
      ST_PAUSE: begin
        // Pause timer loaded on the first cycle out of reset
        if (boot_r) begin
          tmr_load = 1'b1;
          tmr_val = 20'(dwpr_pkg::POWERUP_PAUSE_CYC); // R21
        end else if (tmr_done) begin
          s_nxt.st = ST_WAKE;
          s_nxt.wake_cnt = 4'h0;
        end
      end
      ST_WAKE: begin
        // Row-only cycles with column strobe parked high
        if (tmr_done && s_r.ras_n && s_r.wake_cnt == 4'(dwpr_pkg::WAKE_CYCLES)) begin
          s_nxt.st = ST_IDLE;
          s_nxt.init = 1'b1;
          s_nxt.need_wake = 1'b0;
          s_nxt.ready = 1'b1;
        end else if (tmr_done || s_r.wake_cnt == 4'h0 && s_r.ras_n && !s_r.dq_oe) begin
          s_nxt.ras_n = !s_r.ras_n; // R21
          if (!s_r.ras_n) begin
            s_nxt.wake_cnt = s_r.wake_cnt + 4'h1;
          end
          s_nxt.dq_oe = 1'b1;
          tmr_load = 1'b1;
          tmr_val = s_r.ras_n ? 20'(dwpr_pkg::ROW_ACCESS_CYC) :
            20'(dwpr_pkg::ROW_PRECHARGE_CYC);
        end
      end
      ST_IDLE: begin
        s_nxt.dq_oe = 1'b0;
        if (s_r.need_wake) begin
          s_nxt.st = ST_WAKE;
          s_nxt.wake_cnt = 4'h0;
        end else if (s_r.ref_due) begin
          // Row-only refresh; column strobe stays high
          s_nxt.ref_due = 1'b0;
          s_nxt.cmd = 3'(dwpr_pkg::DWPR_CMD_ROW_REFRESH);
          s_nxt.addr = s_r.ref_row; // R14
          s_nxt.ref_row = s_r.ref_row + 8'h01;
          s_nxt.ras_n = 1'b0;
          s_nxt.st = ST_LEAD;
          tmr_load = 1'b1;
          tmr_val = 20'(dwpr_pkg::ROW_ACCESS_CYC);
        end else if (req_valid && s_r.ready) begin
          s_nxt.cmd = req_cmd;
          s_nxt.col = req_col;
          s_nxt.wdata = req_wdata;
          if (req_cmd == 3'(dwpr_pkg::DWPR_CMD_CBR_REFRESH) ||
              req_cmd == 3'(dwpr_pkg::DWPR_CMD_HIDDEN_REFRESH) || // R17
              (req_cmd == 3'(dwpr_pkg::DWPR_CMD_COUNTER_TEST) &&
               s_r.cbr_cnt == 4'(dwpr_pkg::WAKE_CYCLES))) begin
            s_nxt.cas_n = 1'b0; // R15
            // Gate low only where the test cycle reads
            s_nxt.oe_n = req_cmd != 3'(dwpr_pkg::DWPR_CMD_COUNTER_TEST);
            s_nxt.addr = req_col; // R18 R20
            s_nxt.st = ST_CBR_SETUP;
            tmr_load = 1'b1;
            tmr_val = 20'(dwpr_pkg::COLUMN_BEFORE_ROW_SETUP_CYC);
          end else if (req_cmd == 3'(dwpr_pkg::DWPR_CMD_COUNTER_TEST)) begin
            // Too few initialising refreshes: run one instead
            s_nxt.cmd = 3'(dwpr_pkg::DWPR_CMD_CBR_REFRESH); // R19
            s_nxt.cas_n = 1'b0;
            s_nxt.st = ST_CBR_SETUP;
            tmr_load = 1'b1;
            tmr_val = 20'(dwpr_pkg::COLUMN_BEFORE_ROW_SETUP_CYC);
          end else if (req_cmd == 3'(dwpr_pkg::DWPR_CMD_ROW_REFRESH)) begin
            // Requested row-only refresh; no column phase, no answer
            s_nxt.addr = req_row; // R14
            s_nxt.ras_n = 1'b0;
            s_nxt.st = ST_LEAD;
            tmr_load = 1'b1;
            tmr_val = 20'(dwpr_pkg::ROW_ACCESS_CYC);
          end else begin
            s_nxt.addr = req_row; // R23
            s_nxt.ras_n = 1'b0;
            s_nxt.st = ST_ROW;
            tmr_load = 1'b1;
            tmr_val = 20'(dwpr_pkg::ROW_TO_COLUMN_CYC);
          end
        end else begin
          s_nxt.ready = 1'b1;
        end
      end
      ST_ROW: begin
        if (tmr_done) begin
          s_nxt.addr = s_r.col; // R10
          s_nxt.oe_n = is_write(s_r.cmd) ? 1'b1 : 1'b0; // R5
          if (s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_EARLY_WRITE)) begin
            s_nxt.we_n = 1'b0; // R1
            s_nxt.dq = s_r.wdata;
            s_nxt.dq_oe = 1'b1; // R7
          end
          s_nxt.st = ST_COL;
        end
      end
      ST_COL: begin
        // Column strobe falls one cycle after write setup
        if (s_r.cas_n) begin
          s_nxt.cas_n = 1'b0;
          tmr_load = 1'b1;
          tmr_val = s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_EARLY_WRITE) ?
            20'(dwpr_pkg::WRITE_LEAD_CYC) : 20'(dwpr_pkg::ROW_ACCESS_CYC); // R4
        end else if (tmr_done) begin
          if (s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_EARLY_WRITE)) begin
            s_nxt.st = ST_PAGE; // R2
            s_nxt.rvalid = 1'b1;
          end else begin
            // Unlatched data captured while both strobes low
            s_nxt.rdata = dq_s3_r; // R22
            s_nxt.rvalid = s_r.cmd != 3'(dwpr_pkg::DWPR_CMD_LATE_WRITE);
            s_nxt.st = s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_READ) ? ST_PAGE : ST_LATE;
          end
        end
      end
      ST_LATE: begin
        // Gate high first so the device output floats
        s_nxt.oe_n = 1'b1; // R5
        if (s_r.oe_n) begin
          s_nxt.dq = s_r.wdata;
          s_nxt.dq_oe = 1'b1;
        end
        // Data settles a cycle before the write strobe edge
        if (s_r.dq_oe) begin
          s_nxt.we_n = 1'b0; // R3 R8
          s_nxt.st = ST_LEAD;
          tmr_load = 1'b1;
          tmr_val = 20'(dwpr_pkg::WRITE_LEAD_CYC);
        end
      end
      ST_LEAD: begin
        if (tmr_done) begin
          s_nxt.rvalid = s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_LATE_WRITE);
          s_nxt.st = s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_ROW_REFRESH) ? ST_PRE : ST_PAGE; // R2
        end
      end
      ST_PAGE: begin
        // Row stays low; another column may follow at once
        s_nxt.cas_n = 1'b1;
        s_nxt.we_n = 1'b1;
        s_nxt.oe_n = 1'b1;
        s_nxt.dq_oe = 1'b0;
        if (s_r.cas_n && req_valid && req_page_next && !s_r.ref_due &&
            req_cmd <= 3'(dwpr_pkg::DWPR_CMD_RMW)) begin
          s_nxt.cmd = req_cmd; // R9 R11
          s_nxt.col = req_col;
          s_nxt.wdata = req_wdata;
          s_nxt.addr = req_col;
          s_nxt.oe_n = is_write(req_cmd) ? 1'b1 : 1'b0;
          if (req_cmd == 3'(dwpr_pkg::DWPR_CMD_EARLY_WRITE)) begin
            s_nxt.we_n = 1'b0;
            s_nxt.dq = req_wdata;
            s_nxt.dq_oe = 1'b1;
          end
          s_nxt.st = ST_COL;
        end else if (s_r.cas_n) begin
          s_nxt.st = ST_PRE;
          s_nxt.ras_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val = 20'(dwpr_pkg::ROW_PRECHARGE_CYC);
        end
      end
      ST_CBR_SETUP: begin
        if (tmr_done) begin
          s_nxt.ras_n = 1'b0; // R15
          s_nxt.st = ST_CBR_ROW;
          tmr_load = 1'b1;
          tmr_val = 20'(dwpr_pkg::ROW_ACCESS_CYC);
        end
      end
      ST_CBR_ROW: begin
        if (tmr_done) begin
          if (s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_COUNTER_TEST)) begin
            s_nxt.rdata = dq_s3_r; // R18
            s_nxt.rvalid = 1'b1;
            s_nxt.st = ST_LATE;
          end else begin
            // Device advances its own counter here
            if (s_r.cbr_cnt != 4'(dwpr_pkg::WAKE_CYCLES)) begin
              s_nxt.cbr_cnt = s_r.cbr_cnt + 4'h1; // R16 R19
            end
            s_nxt.cas_n = 1'b1;
            s_nxt.ras_n = 1'b1;
            s_nxt.st = ST_PRE;
            tmr_load = 1'b1;
            tmr_val = 20'(dwpr_pkg::ROW_PRECHARGE_CYC);
          end
        end
      end
      ST_PRE: begin
        s_nxt.ras_n = 1'b1;
        s_nxt.cas_n = 1'b1;
        s_nxt.dq_oe = 1'b0;
        if (tmr_done) begin
          s_nxt.st = ST_IDLE;
          s_nxt.ready = 1'b1;
          s_nxt.rvalid = s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_CBR_REFRESH);
        end else if (!s_r.ras_n) begin
          tmr_load = 1'b1;
          tmr_val = 20'(dwpr_pkg::ROW_PRECHARGE_CYC);
        end
      end
      default: begin
        s_nxt.st = ST_IDLE; // Unused codes recover to idle
      end
    endcase
    // Never offer ready while a refresh or rewake would win the slot
    if (s_nxt.ref_due || s_nxt.need_wake) begin
      s_nxt.ready = 1'b0;
    end
  end

  // Marks the first cycle out of reset to start the pause
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_r <= 1'b1;
    end else begin
      boot_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{st: ST_PAUSE, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
        ref_tmr: 20'(dwpr_pkg::ROW_INTERVAL_CYC - 1),
        idle_tmr: 20'(dwpr_pkg::IDLE_LIMIT_CYC - 1), default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign req_ready = s_r.ready;
  assign rsp_valid = s_r.rvalid;
  assign rsp_rdata = s_r.rdata;
  assign init_done = s_r.init;
  assign row_strobe_n = s_r.ras_n;
  assign column_strobe_n = s_r.cas_n;
  assign write_strobe_n = s_r.we_n;
  assign output_gate_n = s_r.oe_n;
  assign mem_addr = s_r.addr;
  assign mem_dq_out = s_r.dq;
  assign mem_dq_oe = s_r.dq_oe;

  // ****************************************
  // Checks
  // ****************************************
  column_high_row_refresh_a: assert property (@(posedge sys_clk) disable iff (rst) // R14
    (s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_ROW_REFRESH) && !s_r.ras_n) |-> s_r.cas_n)
    else $error("column strobe low in row-only refresh");
  early_write_order_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    $fell(s_r.cas_n) && s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_EARLY_WRITE) |-> !s_r.we_n)
    else $error("early write strobe not low at column fall");
  write_lead_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
    $fell(s_r.we_n) |-> (!s_r.ras_n)[*5])
    else $error("row strobe released inside write lead");
  gate_before_data_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
    $rose(s_r.dq_oe) && !s_r.ras_n |-> s_r.oe_n)
    else $error("data driven with output gate low");
  cbr_setup_a: assert property (@(posedge sys_clk) disable iff (rst) // R15
    $fell(s_r.ras_n) && s_r.st == ST_CBR_ROW |-> $past(!s_r.cas_n, 2))
    else $error("column strobe not set up before row");
  counter_test_init_a: assert property (@(posedge sys_clk) disable iff (rst) // R19
    s_r.st == ST_CBR_ROW && s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_COUNTER_TEST) |->
    s_r.cbr_cnt == 4'h8)
    else $error("counter test before eight refreshes");
  refresh_served_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    s_r.ref_due && s_r.st == ST_IDLE && !s_r.need_wake |=> !s_r.ref_due)
    else $error("due refresh not started");
  wake_before_ready_a: assert property (@(posedge sys_clk) disable iff (rst) // R21
    $rose(s_r.init) |-> s_r.wake_cnt == 4'h8)
    else $error("ready before eight wake cycles");
  cv_page_c: cover property (@(posedge sys_clk) s_r.st == ST_PAGE ##1 s_r.st == ST_COL);
  cv_rmw_c: cover property (@(posedge sys_clk) s_r.cmd == 3'(dwpr_pkg::DWPR_CMD_RMW) &&
    $fell(s_r.we_n));
  cv_cbr_c: cover property (@(posedge sys_clk) s_r.st == ST_CBR_ROW);

endmodule : dwpr_ctrl
`default_nettype wire

/* File: dwpr_pkg.sv */
package dwpr_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int POWERUP_PAUSE_US = 200;
  localparam int POWERUP_PAUSE_CYC = (POWERUP_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_PERIOD_MS = 4;
  localparam int ROW_INTERVAL_NS = 15600;
  localparam int ROW_INTERVAL_CYC = ROW_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int ROW_ACTIVE_MAX_US = 10;
  localparam int ROW_ACTIVE_MAX_CYC = ROW_ACTIVE_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int IDLE_LIMIT_CYC = REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  // Strobe phase lengths in ns (minimums, rounded up to cycles)
  localparam int ROW_PRECHARGE_TIME_NS = 100;
  localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TO_COLUMN_DELAY_NS = 25;
  localparam int ROW_TO_COLUMN_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_ACCESS_TIME_NS = 150;
  localparam int ROW_ACCESS_CYC = (ROW_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLUMN_ACTIVE_TIME_NS = 75;
  localparam int COLUMN_ACTIVE_CYC = (COLUMN_ACTIVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_LEAD_NS = 45;
  localparam int WRITE_LEAD_CYC = (WRITE_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLUMN_BEFORE_ROW_SETUP_NS = 10;
  localparam int COLUMN_BEFORE_ROW_SETUP_CYC =
    (COLUMN_BEFORE_ROW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = 8;
  localparam int TIMER_W = 20;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  localparam int ROWS = 256;

  // ****************************************
  // Commands
  // ****************************************
  typedef enum logic [2:0] {
    DWPR_CMD_READ = 3'h0,
    DWPR_CMD_EARLY_WRITE = 3'h1,
    DWPR_CMD_LATE_WRITE = 3'h2,
    DWPR_CMD_RMW = 3'h3,
    DWPR_CMD_ROW_REFRESH = 3'h4,
    DWPR_CMD_CBR_REFRESH = 3'h5,
    DWPR_CMD_HIDDEN_REFRESH = 3'h6,
    DWPR_CMD_COUNTER_TEST = 3'h7
  } dwpr_cmd_e;

endpackage : dwpr_pkg

/* File: dwpr_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Down-counter with one-cycle done pulse
// ****************************************
module dwpr_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [dwpr_pkg::TIMER_W-1:0] load_val,
  output logic done
);

  typedef struct packed {
    logic [dwpr_pkg::TIMER_W-1:0] cnt;
    logic busy;
    logic done;
  } dwpr_tmr_s;

  dwpr_tmr_s st_r;
  dwpr_tmr_s st_nxt;

  // Load wins over a running count
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (load) begin
      st_nxt.cnt = load_val;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      if (st_r.cnt <= 20'h00001) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 20'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;

endmodule : dwpr_timer
`default_nettype wire

/* File: dwpr_dram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Behavioural 64K x 4 device on the far side
// ****************************************
module dwpr_dram_model (
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_strobe_n,
  input wire logic output_gate_n,
  input wire logic [7:0] mem_addr,
  input wire logic [3:0] dq_in,
  input wire logic dq_in_oe,
  output logic [3:0] dq_out,
  output logic clash
);
  logic [3:0] mem [0:65535];
  logic [7:0] row_l;
  logic [7:0] col_l;
  logic [7:0] cnt_r = 8'h00;
  logic [3:0] last_v = 4'h5;
  logic cbr_l = 1'b0;
  logic wr_l = 1'b0;
  logic drive;
  int cbr_total = 0;
  int ras_total = 0;

  // Cells start cleared so the bench shadow can start cleared too
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 4'h0;
    end
  end

  // Row latch; column low first selects the internal counter
  always @(negedge row_strobe_n) begin
    // Address and strobe leave one register; sample once both settle
    #1;
    ras_total = ras_total + 1;
    cbr_l = (column_strobe_n === 1'b0);
    wr_l = 1'b0;
    row_l = cbr_l ? cnt_r : mem_addr;
    if (cbr_l) begin
      col_l = mem_addr;
      cnt_r = cnt_r + 8'h01;
      cbr_total = cbr_total + 1;
    end
  end

  // Column latch; write strobe already low means early write
  always @(negedge column_strobe_n) begin
    if (row_strobe_n === 1'b0) begin
      col_l = mem_addr;
      wr_l = (write_strobe_n === 1'b0);
      if (wr_l) begin
        mem[{row_l, col_l}] = dq_in;
      end
    end
  end

  // Late write and modify phase take data at the write strobe edge
  always @(negedge write_strobe_n) begin
    if (row_strobe_n === 1'b0 && column_strobe_n === 1'b0 && !wr_l) begin
      wr_l = 1'b1;
      mem[{row_l, col_l}] = dq_in;
    end
  end

  // Unlatched output; released bus shows the inverse, not a held value
  assign drive = !column_strobe_n && !output_gate_n && !wr_l;
  assign dq_out = drive ? mem[{row_l, col_l}] : ~last_v;
  assign clash = drive && dq_in_oe;

  always @(negedge drive) begin
    last_v = mem[{row_l, col_l}];
  end
endmodule : dwpr_dram_model
`default_nettype wire

/* File: dwpr_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dwpr_ctrl_test;
  logic sys_clk, rst, req_valid, req_page_next, req_ready, rsp_valid, init_done;
  logic row_strobe_n, column_strobe_n, write_strobe_n, output_gate_n, mem_dq_oe, clash;
  logic [2:0] req_cmd;
  logic [7:0] req_row, req_col, mem_addr, r, c;
  logic [3:0] req_wdata, rsp_rdata, mem_dq_out, dq_dev;
  logic [4:0] note;
  logic [4:0] notes[$];
  logic [3:0] shadow [0:65535];
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int seed, n, p;

  // ****************************************
  // Clock, design and device
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  dwpr_ctrl dut_u (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
    .req_page_next(req_page_next), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .init_done(init_done), .row_strobe_n(row_strobe_n),
    .column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
    .output_gate_n(output_gate_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
    .mem_dq_oe(mem_dq_oe), .mem_dq_in(dq_dev));

  dwpr_dram_model mem_u (.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n), .mem_addr(mem_addr),
    .dq_in(mem_dq_out), .dq_in_oe(mem_dq_oe), .dq_out(dq_dev), .clash(clash));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Oldest note against each response; stray answers carry no note
  always @(posedge sys_clk) begin
    cycles++;
    if (rsp_valid === 1'b1 && notes.size() != 0) begin
      note = notes.pop_front();
      if (note[4]) check({28'h0, rsp_rdata}, {28'h0, note[3:0]});
    end
    if (init_done === 1'b1) check({31'h0, clash}, 32'h0);
    if (cycles == 60000) begin
      fails++;
      end_sim();
    end
  end

  // ****************************************
  // Request driving
  // ****************************************
  // A page follow-on goes up at once and is held until its own column strobe edge
  task automatic op(input logic [2:0] cmd, input logic [7:0] row, input logic [7:0] col,
    input logic page, input logic pg);
    logic [3:0] wd;
    logic cprev;
    wd = 4'($random(seed));
    case (cmd)
      3'h0: notes.push_back({1'b1, shadow[{row, col}]});
      3'h1, 3'h2, 3'h3: begin
        notes.push_back({cmd == 3'h3, shadow[{row, col}]});
        shadow[{row, col}] = wd;
      end
      3'h5: notes.push_back(5'h00);
      default: ;
    endcase
    if (!pg) @(negedge sys_clk);
    req_valid = 1'b1;
    req_cmd = cmd;
    req_row = row;
    req_col = col;
    req_wdata = wd;
    req_page_next = page;
    n = 0;
    cprev = column_strobe_n;
    @(posedge sys_clk);
    while (!((!pg && req_ready === 1'b1) || (pg && cprev && !column_strobe_n)) && n < 5000)
    begin
      cprev = column_strobe_n;
      @(posedge sys_clk);
      n++;
    end
    if (n >= 5000) fails++;
    @(negedge sys_clk);
    req_valid = 1'b0;
    req_page_next = 1'b0;
  endtask : op

  // Waits for all answers, and for ready too unless a page stays open
  task automatic settle(input logic rdy);
    n = 0;
    while ((notes.size() != 0 || (rdy && req_ready !== 1'b1)) && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 5000) fails++;
  endtask : settle

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 98869;
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = 3'h0;
    req_row = 8'h00;
    req_col = 8'h00;
    req_wdata = 4'h0;
    req_page_next = 1'b0;
    for (int i = 0; i < 65536; i++) shadow[i] = 4'h0;
    repeat (10) @(negedge sys_clk);
    check({row_strobe_n, column_strobe_n, mem_dq_oe, req_ready}, 32'hc);
    rst = 1'b0;
    n = 0;
    while (init_done !== 1'b1 && n < 40000) begin
      @(negedge sys_clk);
      n++;
    end
    check({31'h0, init_done}, 32'h1);
    check(32'(n >= dwpr_pkg::POWERUP_PAUSE_CYC), 32'h1);
    check(32'(mem_u.ras_total >= dwpr_pkg::WAKE_CYCLES), 32'h1);
    $display("test wake done");
    settle(1'b1);
    // Every write kind, boundary columns, a row refresh between write and read
    for (int i = 0; i < 12; i++) begin
      r = 8'($random(seed));
      c = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : 8'($random(seed)));
      op(3'(1 + i % 3), r, c, 1'b0, 1'b0);
      settle(1'b1);
      if (i % 4 == 0) op(3'h4, r, 8'h00, 1'b0, 1'b0);
      settle(1'b1);
      op(3'h0, r, c, 1'b0, 1'b0);
      settle(1'b1);
    end
    $display("test writes done");
    // Mixed page sequence on one open row
    r = 8'($random(seed));
    op(3'h1, r, 8'h00, 1'b1, 1'b0);
    settle(1'b0);
    op(3'h3, r, 8'hff, 1'b1, 1'b1);
    settle(1'b0);
    op(3'h0, r, 8'h00, 1'b1, 1'b1);
    settle(1'b1);
    op(3'h0, r, 8'hff, 1'b0, 1'b0);
    settle(1'b1);
    $display("test page done");
    // Idle: periodic refresh must keep coming
    p = mem_u.ras_total;
    repeat (2 * dwpr_pkg::ROW_INTERVAL_CYC + 200) @(negedge sys_clk);
    check(32'(mem_u.ras_total - p >= 2), 32'h1);
    $display("test refresh done");
    // Counter test too early becomes a column-first refresh
    p = mem_u.cbr_total;
    op(3'h7, 8'h00, 8'h33, 1'b0, 1'b0);
    settle(1'b1);
    check(32'(mem_u.cbr_total - p), 32'h1);
    for (int i = 0; i < 7; i++) begin
      op(3'h5, 8'($random(seed)), 8'h00, 1'b0, 1'b0);
      settle(1'b1);
    end
    check(32'(mem_u.cbr_total - p), 32'h8);
    op(3'h6, 8'h00, 8'h00, 1'b0, 1'b0);
    settle(1'b1);
    check(32'(mem_u.cbr_total - p), 32'h9);
    p = mem_u.cbr_total;
    op(3'h7, 8'h00, 8'h33, 1'b0, 1'b0);
    settle(1'b1);
    check(32'(mem_u.cbr_total - p), 32'h1);
    $display("test counter done");
    end_sim();
  end
endmodule : dwpr_ctrl_test
`default_nettype wire
